// File: aes_round_pkg.sv
// Purpose: Shared types and constants for the AES round primitive block
// Assumes: 128-bit state, byte n at bits 8n+7..8n, element (row i, col j) is byte 4j+i
// Notes:   Operation codes are local encodings of this block
package aes_round_pkg;

    localparam int unsigned BYTE_W  = 8;
    localparam int unsigned NBYTES  = 16;
    localparam int unsigned NROWS   = 4;
    localparam int unsigned WORD_W  = 32;
    localparam int unsigned STATE_W = 128;

    // Field reduction constant for x^8+x^4+x^3+x+1, with x^8 removed
    localparam logic [7:0] FIELD_POLY = 8'h1b;
    localparam logic [7:0] MUL_TWO    = 8'h02;
    localparam logic [7:0] MUL_THREE  = 8'h03;

    localparam logic [127:0] STATE_RESET = 128'h0;
    localparam logic [31:0]  WORD_RESET  = 32'h0;

    typedef enum logic [2:0] {
        OP_SUB_BYTES  = 3'b000,
        OP_SHIFT_ROWS = 3'b001,
        OP_MIX_COLS   = 3'b010,
        OP_ROT_WORD   = 3'b011,
        OP_FIELD_MUL  = 3'b100,
        OP_ENC_ROUND  = 3'b101,
        OP_ENC_FINAL  = 3'b110
    } prim_op_t;

    typedef struct packed {
        logic           valid;
        prim_op_t       op;
        logic [127:0]   state;
        logic [127:0]   round_key;
        logic [7:0]     mul_a;
        logic [7:0]     mul_b;
        logic [31:0]    word;
    } prim_req_t;

    typedef struct packed {
        logic           valid;
        logic [127:0]   state;
        logic [7:0]     product;
        logic [31:0]    word;
    } prim_rsp_t;

endpackage

// File: aes_round_primitives.sv
// Purpose: AES forward round primitives issued by the execution pipeline
// Assumes: Request fields are synchronous to ref_clk; one request per cycle
// Notes:   Combinational transforms, result registered one cycle after request
`timescale 1ns/100ps

module aes_round_primitives (
    // Clock and reset
    input  wire logic                    ref_clk,
    input  wire logic                    arst_n,
    // Request from execution pipeline
    input  wire aes_round_pkg::prim_req_t req,
    // Registered result
    output aes_round_pkg::prim_rsp_t     rsp
);

    // ------------------------------------------------------------
    // Field arithmetic
    // ------------------------------------------------------------
    function automatic logic [7:0] field_add(input logic [7:0] a, input logic [7:0] b);
        field_add = a ^ b;
    endfunction

    function automatic logic [7:0] field_mul_two(input logic [7:0] a);
        field_mul_two = {a[6:0], 1'b0} ^ (a[7] ? aes_round_pkg::FIELD_POLY : 8'h00);
    endfunction

    function automatic logic [7:0] field_mul_three(input logic [7:0] a);
        field_mul_three = field_add(field_mul_two(a), a);
    endfunction

    // Shift-and-add form equals carry-less product reduced step by step
    function automatic logic [7:0] field_byte_multiply(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] acc;
        logic [7:0] pw;
        acc = 8'h00;
        pw  = a;
        for (int k = 0; k < 8; k++) begin
            if (b[k]) begin
                acc = field_add(acc, pw);
            end
            pw = field_mul_two(pw);
        end
        field_byte_multiply = acc;
    endfunction

    function automatic logic [7:0] sbox(input logic [7:0] x);
        logic [2047:0] tbl;
        // Row 0 sits at the right-hand end, so entry x is bits 8x+7..8x
        tbl = {
            128'h16bb54b00f2d99416842e6bf0d89a18c, 128'hdf2855cee9871e9b948ed9691198f8e1,
            128'h9e1dc186b95735610ef6034866b53e70, 128'h8a8bbd4b1f74dde8c6b4a61c2e2578ba,
            128'h08ae7a65eaf4566ca94ed58d6d37c8e7, 128'h79e4959162acd3c25c2406490a3a32e0,
            128'hdb0b5ede14b8ee4688902a22dc4f8160, 128'h73195d643d7ea7c41744975fec130ccd,
            128'hd2f3ff1021dab6bcf5389d928f40a351, 128'ha89f3c507f02f94585334d43fbaaefd0,
            128'hcf584c4a39becb6a5bb1fc20ed00d153, 128'h842fe329b3d63b52a05a6e1b1a2c8309,
            128'h75b227ebe28012079a059618c323c704, 128'h1531d871f1e5a534ccf73f362693fdb7,
            128'hc072a49cafa2d4adf04759fa7dc982ca, 128'h76abd7fe2b670130c56f6bf27b777c63
        };
        sbox = tbl[{x[7:4], x[3:0], 3'b000} +: 8];
    endfunction

    // byte 4j+i, row i column j
    function automatic logic [7:0] elem(input logic [127:0] s, input int unsigned r,
                                       input int unsigned c);
        elem = s[((c % 4) * 4 + (r % 4)) * 8 +: 8];
    endfunction

    // ------------------------------------------------------------
    // State transforms
    // ------------------------------------------------------------
    function automatic logic [127:0] sub_bytes(input logic [127:0] s);
        logic [127:0] o;
        o = aes_round_pkg::STATE_RESET;
        for (int n = 0; n < 16; n++) begin
            o[n*8 +: 8] = sbox(s[n*8 +: 8]);
        end
        sub_bytes = o;
    endfunction

    function automatic logic [127:0] shift_rows(input logic [127:0] s);
        logic [127:0] o;
        o = aes_round_pkg::STATE_RESET;
        for (int j = 0; j < 4; j++) begin
            for (int i = 0; i < 4; i++) begin
                o[(j*4 + i)*8 +: 8] = elem(s, i, j + i);
            end
        end
        shift_rows = o;
    endfunction

    function automatic logic [127:0] mix_columns(input logic [127:0] s);
        logic [127:0] o;
        o = aes_round_pkg::STATE_RESET;
        for (int j = 0; j < 4; j++) begin
            for (int i = 0; i < 4; i++) begin
                o[(j*4 + i)*8 +: 8] = field_add(field_add(field_mul_two(elem(s, i, j)),
                    field_mul_three(elem(s, i + 1, j))),
                    field_add(elem(s, i + 2, j), elem(s, i + 3, j)));
            end
        end
        mix_columns = o;
    endfunction

    function automatic logic [31:0] rot_word(input logic [31:0] w);
        rot_word = {w[7:0], w[31:8]};
    endfunction

    // ------------------------------------------------------------
    // Operation select
    // ------------------------------------------------------------
    // operands are taken as-is, little-endian, no reversal
    wire logic [127:0] shifted_sub = shift_rows(sub_bytes(req.state));
    wire logic [127:0] round_out   = mix_columns(shifted_sub) ^ req.round_key;
    wire logic [127:0] final_out   = shifted_sub ^ req.round_key;
    wire logic [7:0]   mul_out     = field_byte_multiply(req.mul_a, req.mul_b);
    wire logic [31:0]  rot_out     = rot_word(req.word);

    aes_round_pkg::prim_rsp_t next_rsp;

    always_comb begin
        next_rsp         = '0;
        next_rsp.valid   = req.valid;
        next_rsp.product = mul_out;
        next_rsp.word    = rot_out;
        unique case (req.op)
            aes_round_pkg::OP_SUB_BYTES:  next_rsp.state = sub_bytes(req.state);
            aes_round_pkg::OP_SHIFT_ROWS: next_rsp.state = shift_rows(req.state);
            aes_round_pkg::OP_MIX_COLS:   next_rsp.state = mix_columns(req.state);
            aes_round_pkg::OP_ENC_ROUND:  next_rsp.state = round_out;
            aes_round_pkg::OP_ENC_FINAL:  next_rsp.state = final_out;
            default:                      next_rsp.state = req.state;
        endcase
    end

    // ------------------------------------------------------------
    // Output register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rsp <= '0;
        end else begin
            rsp <= next_rsp;
        end
    end

endmodule

// File: aes_round_primitives_props.sv
// Purpose: Port-level properties of the AES round primitives
// Assumes: Result registered one cycle after the request edge
// Notes:   Relations hold whatever req.valid says, as results are always computed
`timescale 1ns/100ps
module aes_round_primitives_props (
    input wire logic                     ref_clk,
    input wire logic                     arst_n,
    input wire aes_round_pkg::prim_req_t req,
    input wire aes_round_pkg::prim_rsp_t rsp
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    property p_rot; 1'b1 |=> rsp.word == {$past(req.word[7:0]), $past(req.word[31:8])}; endproperty
    a_rot: assert property (p_rot) else $error("word rotate wrong");
    property p_mul1; req.mul_b == 8'h01 |=> rsp.product == $past(req.mul_a); endproperty
    a_mul1: assert property (p_mul1) else $error("product by one wrong");
    property p_mul2; req.mul_b == 8'h02 |=> rsp.product ==
        ({$past(req.mul_a[6:0]), 1'b0} ^ ($past(req.mul_a[7]) ? 8'h1b : 8'h00)); endproperty
    a_mul2: assert property (p_mul2) else $error("product by two wrong");
    property p_mul3; req.mul_b == 8'h03 |=> rsp.product == ($past(req.mul_a) ^
        {$past(req.mul_a[6:0]), 1'b0} ^ ($past(req.mul_a[7]) ? 8'h1b : 8'h00)); endproperty
    a_mul3: assert property (p_mul3) else $error("product by three wrong");
    property p_row0; req.op == aes_round_pkg::OP_SHIFT_ROWS |=>
        rsp.state[7:0] == $past(req.state[7:0]) && rsp.state[15:8] == $past(req.state[47:40]);
    endproperty
    a_row0: assert property (p_row0) else $error("row shift wrong");
    property p_row3; req.op == aes_round_pkg::OP_SHIFT_ROWS |=>
        rsp.state[31:24] == $past(req.state[127:120]); endproperty
    a_row3: assert property (p_row3) else $error("row three placement wrong");
    property p_mixu; req.op == aes_round_pkg::OP_MIX_COLS && req.state == {16{req.state[7:0]}}
        |=> rsp.state == $past(req.state); endproperty
    a_mixu: assert property (p_mixu) else $error("uniform column not kept");
    property p_sub0; req.op == aes_round_pkg::OP_SUB_BYTES && req.state == 128'h0
        |=> rsp.state == {16{8'h63}}; endproperty
    a_sub0: assert property (p_sub0) else $error("zero substitution wrong");
endmodule

// File: exec_pipe_model.sv
// Purpose: Execution pipeline issuing one primitive request at a time
// Assumes: Drives 1 ns after the rising edge, one valid cycle then one released cycle per request
// Notes:   On release valid is cleared and state and word are inverted so stale values never look valid
`timescale 1ns/100ps
module exec_pipe_model (
    input  wire logic               ref_clk,
    output aes_round_pkg::prim_req_t req
);
    initial req = '0;
    task automatic send(input logic [2:0] op, input logic [127:0] st,
                        input logic [7:0] a, input logic [7:0] b, input logic [31:0] w);
        @(posedge ref_clk);
        #1;
        req = '{1'b1, aes_round_pkg::prim_op_t'(op), st, ~st, a, b, w};
        @(posedge ref_clk);
        #1;
        req.valid = 1'b0;
        req.state = ~st;
        req.word  = ~w;
    endtask
endmodule

// File: aes_round_primitives_tb_top.sv
// Purpose: Self-checking bench for the AES round primitives
// Assumes: 25 MHz clock, reset held for ten cycles
// Notes:   Expected values worked out by hand from the transform definitions
`timescale 1ns/100ps
module aes_round_primitives_tb_top;
    logic                     ref_clk;
    logic                     arst_n;
    aes_round_pkg::prim_req_t req;
    aes_round_pkg::prim_rsp_t rsp;
    int                       miscompares;
    int                       tests_run;
    exec_pipe_model pipe (.ref_clk(ref_clk), .req(req));
    aes_round_primitives dut (.ref_clk(ref_clk), .arst_n(arst_n), .req(req), .rsp(rsp));
    task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic run_op(input logic [2:0] op, input logic [127:0] st, input logic [127:0] exp);
        pipe.send(op, st, 8'h00, 8'h00, 32'h0);
        chk(rsp.state, exp);
    endtask
    // ------------------------------------------------
    // Scenarios
    // ------------------------------------------------
    task automatic t_sub();
        run_op(3'b000, 128'h0, {16{8'h63}});
        run_op(3'b000, 128'hff0100, {{13{8'h63}}, 8'h16, 8'h7c, 8'h63});
        $display("substitution done");
    endtask
    task automatic t_shift();
        logic [127:0] st;
        logic [127:0] exp;
        for (int n = 0; n < 16; n++) begin
            st[8*n +: 8]  = 8'(n);
            exp[8*n +: 8] = 8'(4 * (((n / 4) + (n % 4)) % 4) + (n % 4));
        end
        run_op(3'b001, st, exp);
        $display("row shift done");
    endtask
    task automatic t_mix();
        run_op(3'b010, {4{32'h455313db}}, {4{32'hbca14d8e}});
        run_op(3'b010, {16{8'h5a}}, {16{8'h5a}});
        $display("column mix done");
    endtask
    task automatic t_misc();
        logic [23:0] tab [4];
        tab = '{24'h5783c1, 24'h80021b, 24'h5703f9, 24'hc101c1};
        for (int k = 0; k < 4; k++) begin
            pipe.send(3'b100, 128'h1, tab[k][23:16], tab[k][15:8], 32'h44332211);
            chk(128'(rsp.product), 128'(tab[k][7:0]));
        end
        chk(128'(rsp.word), 128'h11443322);
        $display("multiply and rotate done");
    endtask
    task automatic t_enc();
        // Rows constant across columns, so row shift keeps the substituted column db 13 53 45
        logic [127:0] st;
        st = {4{32'h6850829f}};
        run_op(3'b101, st, {4{32'h2b0e30ee}});
        chk(128'(rsp.valid), 128'h1);
        run_op(3'b110, st, {4{32'hd2fc6ebb}});
        run_op(3'b011, st, st);
        run_op(3'b111, st, st);
        @(posedge ref_clk);
        #1;
        chk(128'(rsp.valid), 128'h0);
        $display("encrypt rounds done");
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    initial begin
        arst_n = 1'b0;
        repeat (10) @(posedge ref_clk);
        #1 arst_n = 1'b1;
        t_sub();
        t_shift();
        t_mix();
        t_misc();
        t_enc();
        stop_test();
    end
    // Run needs about 40 cycles; a hang is cut well past that
    initial begin
        #40000;
        miscompares++;
        stop_test();
    end
endmodule
bind aes_round_primitives aes_round_primitives_props props (.ref_clk(ref_clk), .arst_n(arst_n),
    .req(req), .rsp(rsp));
